// >>> fbm_map.vh
// Register map, field positions and reset values of the FIFO read port block
`ifndef FBM_MAP_VH
`define FBM_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define FBM_ADDR_CTRL      12'h000
`define FBM_ADDR_STATUS    12'h004
`define FBM_ADDR_OFFSET    12'h008
`define FBM_ADDR_IRQ_STS   12'h00C
`define FBM_ADDR_IRQ_MASK  12'h010

// ****************************************
// Control register fields
// ****************************************
`define FBM_CTRL_SIZE_LO   0
`define FBM_CTRL_SIZE_HI   1
`define FBM_CTRL_SWAP_LO   2
`define FBM_CTRL_SWAP_HI   3
`define FBM_CTRL_ENDIAN    4
`define FBM_CTRL_PGEN      5
`define FBM_CTRL_ODD       6
`define FBM_CTRL_RESET     7'h00

// ****************************************
// Bus size codes {high, low}
// ****************************************
`define FBM_SIZE_LONG      2'h0
`define FBM_SIZE_WORD      2'h1
`define FBM_SIZE_BYTE      2'h2
`define FBM_SIZE_MAIL      2'h3

// ****************************************
// Status and offset fields
// ****************************************
`define FBM_STS_COUNT_LSB  8
`define FBM_OFF_AF_LSB     16
`define FBM_OFF_RESET      6'h08

// ****************************************
// Interrupt event bits
// ****************************************
`define FBM_IRQ_EMPTY      0
`define FBM_IRQ_FULL       1
`define FBM_IRQ_MAIL       2
`define FBM_IRQ_REFUSED    3
`define FBM_IRQ_W          4

`endif

// >>> fbm_ram.v
// Storage array of the FIFO, written by port A and read at the read pointer
`timescale 1ns/1ps
module fbm_ram #(
  parameter DEPTH = 64,
  parameter AW    = 6,
  parameter WIDTH = 36
) (
  input  wire             core_clk_i,
  input  wire             wr_en_i,
  input  wire [AW-1:0]    wr_addr_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire [AW-1:0]    rd_addr_i,
  output wire [WIDTH-1:0] rd_data_o
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];

  // ****************************************
  // Write and read
  // ****************************************
  always @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem_q[rd_addr_i];

endmodule

// >>> fbm_swap.v
// Byte order swap and optional parity generation of one 36-bit long word
`timescale 1ns/1ps
module fbm_swap (
  input  wire [35:0] word_i,
  input  wire [1:0]  swap_i,
  input  wire        pgen_i,
  input  wire        odd_i,
  output wire [35:0] word_o
);

  reg  [35:0] sw;
  wire [35:0] gen;

  // ****************************************
  // Byte swap
  // ****************************************
  always @* begin
    case (swap_i)
      2'h0: sw = word_i;
      2'h1: sw = {word_i[8:0], word_i[17:9], word_i[26:18], word_i[35:27]};
      2'h2: sw = {word_i[17:9], word_i[8:0], word_i[35:27], word_i[26:18]};
      default: sw = {word_i[26:18], word_i[35:27], word_i[8:0], word_i[17:9]};
    endcase
  end

  // ****************************************
  // Parity per byte lane, output only
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign gen[g*9+7:g*9] = sw[g*9+7:g*9];
      assign gen[g*9+8]     = pgen_i ? (^sw[g*9+7:g*9]) ^ odd_i : sw[g*9+8];
    end
  endgenerate

  assign word_o = gen;

endmodule

// >>> fbm_top.v
// Read port of a 64 x 36 FIFO with bus sizing, byte swap, mailbox and APB registers
//
// Overview of operation
// - Size select both high puts the outgoing mailbox on the read bus.
// - Byte reads leave the other lanes holding the last output register data.
// - Byte swaps low-low and low-high give the tabled big and little lane orders.
// - Byte swap high-low swaps the two half-words; high-high swaps the bytes within each half-word.
// - Empty flag deasserts in the read cycle after a write.
// - In word or byte size, empty asserts only on the last part read.
// - Full flag deasserts in the write cycle after a freeing read.
// - In word or byte size, only the last part read frees a location.
// - Almost-empty deasserts a cycle after the write, referenced to last part read.
// - Almost-full deasserts a cycle after the read, referenced to last part read.
// - Size selects both low choose long word, low-high choose word and high-low choose byte.
// - Parity generate low passes the stored parity bits unchanged.
// - Parity generation on mailbox output leaves the mailbox contents unchanged.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fbm_map.vh"
module fbm_top #(
  parameter DEPTH = 64,
  parameter AW    = 6,
  parameter WIDTH = 36
) (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire [11:0] paddr_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg         irq_o,
  input  wire        write_port_select_n_i,
  input  wire        write_port_direction_i,
  input  wire        write_port_enable_i,
  input  wire        write_port_mailbox_select_i,
  input  wire [35:0] write_data_i,
  input  wire        read_port_select_n_i,
  input  wire        read_port_direction_i,
  input  wire        read_port_enable_i,
  input  wire        read_port_mailbox_select_i,
  output reg  [35:0] read_data_o,
  output reg         empty_flag_n_o,
  output reg         full_flag_n_o,
  output reg         almost_empty_flag_n_o,
  output reg         almost_full_flag_n_o,
  output reg         mail_full_o
);

  // ****************************************
  // Declarations
  // ****************************************
  reg  [6:0]       ctrl_q;
  reg  [5:0]       ae_off_q;
  reg  [5:0]       af_off_q;
  reg  [3:0]       irq_mask_q;
  reg  [3:0]       irq_sts_q;
  reg  [3:0]       irq_sts_d;
  reg  [3:0]       rd_clr_q;
  reg  [35:0]      mailbox_q;
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      count_q;
  reg  [AW:0]      count_d;
  reg  [1:0]       part_q;
  reg  [1:0]       part_d;
  reg  [35:0]      out_d;
  reg  [31:0]      rd_mux;
  reg              addr_hit;
  wire [35:0]      mem_rdata;
  wire [35:0]      fifo_sw;
  wire [35:0]      mail_gen;
  wire [1:0]       size_sel;
  wire             wr_acc;
  wire             rd_acc;
  wire             fifo_push;
  wire             mbx_wr;
  wire             mbx_rd;
  wire             fifo_rd;
  wire             last_part;
  wire             fifo_pop;
  wire             refused;
  wire             apb_setup;
  wire             apb_done;
  wire [3:0]       irq_ev;
  wire [AW:0]      depth_c;

  assign depth_c  = DEPTH[AW:0];
  assign size_sel = {ctrl_q[`FBM_CTRL_SIZE_HI], ctrl_q[`FBM_CTRL_SIZE_LO]};

  // ****************************************
  // Byte lane pick
  // ****************************************
  function [8:0] byte_of;
    input [35:0] w;
    input [1:0]  idx;
    begin
      case (idx)
        2'h0:    byte_of = w[35:27];
        2'h1:    byte_of = w[26:18];
        2'h2:    byte_of = w[17:9];
        default: byte_of = w[8:0];
      endcase
    end
  endfunction

  // ****************************************
  // Port access decode
  // ****************************************
  assign wr_acc    = ~write_port_select_n_i & write_port_direction_i & write_port_enable_i;
  assign rd_acc    = ~read_port_select_n_i & ~read_port_direction_i & read_port_enable_i;
  assign fifo_push = wr_acc & ~write_port_mailbox_select_i & (count_q != depth_c);
  assign mbx_wr    = wr_acc & write_port_mailbox_select_i;
  assign mbx_rd    = rd_acc & (read_port_mailbox_select_i | (size_sel == `FBM_SIZE_MAIL));
  assign fifo_rd   = rd_acc & ~mbx_rd & (count_q != {(AW+1){1'b0}});
  assign refused   = (wr_acc & ~write_port_mailbox_select_i & (count_q == depth_c))
                   | (rd_acc & ~mbx_rd & (count_q == {(AW+1){1'b0}}));

  // Last part of a long word for the current size
  assign last_part = (size_sel == `FBM_SIZE_LONG)
                   | ((size_sel == `FBM_SIZE_WORD) & (part_q != 2'h0))
                   | ((size_sel == `FBM_SIZE_BYTE) & (part_q == 2'h3));
  assign fifo_pop  = fifo_rd & last_part;

  // ****************************************
  // Storage and swap
  // ****************************************
  fbm_ram #(
    .DEPTH (DEPTH),
    .AW    (AW),
    .WIDTH (WIDTH)
  ) u_ram (
    .core_clk_i (core_clk_i),
    .wr_en_i    (fifo_push),
    .wr_addr_i  (wr_ptr_q),
    .wr_data_i  (write_data_i),
    .rd_addr_i  (rd_ptr_q),
    .rd_data_o  (mem_rdata)
  );

  fbm_swap u_fifo_swap (
    .word_i (mem_rdata),
    .swap_i ({ctrl_q[`FBM_CTRL_SWAP_HI], ctrl_q[`FBM_CTRL_SWAP_LO]}),
    .pgen_i (ctrl_q[`FBM_CTRL_PGEN]),
    .odd_i  (ctrl_q[`FBM_CTRL_ODD]),
    .word_o (fifo_sw)
  );

  // Mailbox parity is formed on the way out only
  fbm_swap u_mail_gen (
    .word_i (mailbox_q),
    .swap_i (2'h0),
    .pgen_i (ctrl_q[`FBM_CTRL_PGEN]),
    .odd_i  (ctrl_q[`FBM_CTRL_ODD]),
    .word_o (mail_gen)
  );

  // ****************************************
  // Count and part counter next state
  // ****************************************
  always @* begin
    count_d = count_q;
    if (fifo_push & ~fifo_pop) begin
      count_d = count_q + {{AW{1'b0}}, 1'b1};
    end else if (fifo_pop & ~fifo_push) begin
      count_d = count_q - {{AW{1'b0}}, 1'b1};
    end
    part_d = part_q;
    if (fifo_rd) begin
      part_d = last_part ? 2'h0 : part_q + 2'h1;
    end
  end

  // ****************************************
  // Read bus lane steering
  // ****************************************
  always @* begin
    out_d = read_data_o;
    if (mbx_rd) begin
      out_d = mail_gen;
    end else if (fifo_rd) begin
      case (size_sel)
        `FBM_SIZE_WORD: begin
          if (ctrl_q[`FBM_CTRL_ENDIAN]) begin
            out_d[35:18] = part_q[0] ? fifo_sw[17:0] : fifo_sw[35:18];
          end else begin
            out_d[17:0] = part_q[0] ? fifo_sw[35:18] : fifo_sw[17:0];
          end
        end
        `FBM_SIZE_BYTE: begin
          if (ctrl_q[`FBM_CTRL_ENDIAN]) begin
            out_d[35:27] = byte_of(fifo_sw, part_q);
          end else begin
            out_d[8:0] = byte_of(fifo_sw, 2'h3 - part_q);
          end
        end
        default: begin
          out_d = fifo_sw;
        end
      endcase
    end
  end

  // ****************************************
  // Datapath and flag registers
  // ****************************************
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q              <= {AW{1'b0}};
      rd_ptr_q              <= {AW{1'b0}};
      count_q               <= {(AW+1){1'b0}};
      part_q                <= 2'h0;
      mailbox_q             <= 36'h0_0000_0000;
      read_data_o           <= 36'h0_0000_0000;
      empty_flag_n_o        <= 1'b0;
      full_flag_n_o         <= 1'b1;
      almost_empty_flag_n_o <= 1'b0;
      almost_full_flag_n_o  <= 1'b1;
      mail_full_o           <= 1'b0;
    end else begin
      if (fifo_push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (fifo_pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      count_q     <= count_d;
      part_q      <= part_d;
      read_data_o <= out_d;
      if (mbx_wr) begin
        mailbox_q <= write_data_i;
      end
      mail_full_o           <= mbx_wr | (mail_full_o & ~mbx_rd);
      empty_flag_n_o        <= (count_d != {(AW+1){1'b0}});
      full_flag_n_o         <= (count_d != depth_c);
      almost_empty_flag_n_o <= (count_d > {1'b0, ae_off_q});
      almost_full_flag_n_o  <= (count_d < depth_c - {1'b0, af_off_q});
    end
  end

  // ****************************************
  // Interrupt events
  // ****************************************
  assign irq_ev[`FBM_IRQ_EMPTY]   = fifo_pop & (count_d == {(AW+1){1'b0}});
  assign irq_ev[`FBM_IRQ_FULL]    = fifo_push & (count_d == depth_c);
  assign irq_ev[`FBM_IRQ_MAIL]    = mbx_wr;
  assign irq_ev[`FBM_IRQ_REFUSED] = refused;

  // ****************************************
  // APB slave
  // ****************************************
  assign apb_setup = psel_i & ~penable_i;
  assign apb_done  = psel_i & penable_i & pready_o;

  always @* begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr_i)
      `FBM_ADDR_CTRL: begin
        rd_mux[6:0] = ctrl_q;
      end
      `FBM_ADDR_STATUS: begin
        rd_mux[4:0] = {mail_full_o, almost_full_flag_n_o, almost_empty_flag_n_o,
                       full_flag_n_o, empty_flag_n_o};
        rd_mux[`FBM_STS_COUNT_LSB+AW:`FBM_STS_COUNT_LSB] = count_q;
      end
      `FBM_ADDR_OFFSET: begin
        rd_mux[5:0] = ae_off_q;
        rd_mux[`FBM_OFF_AF_LSB+5:`FBM_OFF_AF_LSB] = af_off_q;
      end
      `FBM_ADDR_IRQ_STS: begin
        rd_mux[3:0] = irq_sts_q;
      end
      `FBM_ADDR_IRQ_MASK: begin
        rd_mux[3:0] = irq_mask_q;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Read clears only the bits that were returned; a new event wins
  always @* begin
    irq_sts_d = irq_sts_q & ~(apb_done ? rd_clr_q : 4'h0);
    irq_sts_d = irq_sts_d | irq_ev;
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q     <= `FBM_CTRL_RESET;
      ae_off_q   <= `FBM_OFF_RESET;
      af_off_q   <= `FBM_OFF_RESET;
      irq_mask_q <= 4'h0;
      irq_sts_q  <= 4'h0;
      rd_clr_q   <= 4'h0;
      prdata_o   <= 32'h0000_0000;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      pready_o <= apb_setup;
      if (apb_setup) begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_o <= ~addr_hit;
        rd_clr_q  <= (~pwrite_i & (paddr_i == `FBM_ADDR_IRQ_STS)) ? irq_sts_q : 4'h0;
      end else if (apb_done) begin
        rd_clr_q  <= 4'h0;
      end
      if (apb_done & pwrite_i) begin
        case (paddr_i)
          `FBM_ADDR_CTRL: begin
            ctrl_q <= pwdata_i[6:0];
          end
          `FBM_ADDR_OFFSET: begin
            ae_off_q <= pwdata_i[5:0];
            af_off_q <= pwdata_i[`FBM_OFF_AF_LSB+5:`FBM_OFF_AF_LSB];
          end
          `FBM_ADDR_IRQ_MASK: begin
            irq_mask_q <= pwdata_i[3:0];
          end
          default: begin
            ctrl_q <= ctrl_q;
          end
        endcase
      end
      irq_sts_q <= irq_sts_d;
      irq_o     <= |(irq_sts_d & irq_mask_q);
    end
  end

endmodule

// >>> fbm_port_b_host.sv
// Port B reader model: issues single reads with optional idle cycles
`timescale 1ns/1ps
module fbm_port_b_host (
  input  logic core_clk_i,
  output logic sel_n_o,
  output logic dir_o,
  output logic en_o,
  output logic mb_o
);
  // ****************************************
  // Read request
  // ****************************************
  initial begin
    sel_n_o = 1'b1;
    dir_o   = 1'b1;
    en_o    = 1'b0;
    mb_o    = 1'b0;
  end
  task automatic rd(input logic m, input int gap);
    repeat (gap) @(posedge core_clk_i);
    @(posedge core_clk_i);
    sel_n_o <= 1'b0;
    dir_o   <= 1'b0;
    en_o    <= 1'b1;
    mb_o    <= m;
    @(posedge core_clk_i);
    sel_n_o <= 1'b1;
    dir_o   <= 1'b1;
    en_o    <= 1'b0;
    mb_o    <= 1'b0;
  endtask
endmodule

// >>> fbm_top_chk.sv
// Port checks of the FIFO read port block
`timescale 1ns/1ps
module fbm_top_chk (
  input logic        core_clk_i,
  input logic        rst_n_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pready_o,
  input logic        write_port_select_n_i,
  input logic        write_port_direction_i,
  input logic        write_port_enable_i,
  input logic        write_port_mailbox_select_i,
  input logic        read_port_select_n_i,
  input logic        read_port_direction_i,
  input logic        read_port_enable_i,
  input logic        read_port_mailbox_select_i,
  input logic [35:0] read_data_o,
  input logic        empty_flag_n_o,
  input logic        full_flag_n_o,
  input logic        almost_empty_flag_n_o,
  input logic        almost_full_flag_n_o,
  input logic        mail_full_o
);
  // ****************************************
  // Requests and assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire wreq = !write_port_select_n_i && write_port_direction_i && write_port_enable_i;
  wire push = wreq && !write_port_mailbox_select_i;
  wire rreq = !read_port_select_n_i && !read_port_direction_i && read_port_enable_i;
  wire rmb  = rreq && read_port_mailbox_select_i;
  a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_empty_clears: assert property (push && !empty_flag_n_o |=> empty_flag_n_o)
    else $error("empty flag stayed low after write");
  a_empty_rise_cause: assert property ($rose(empty_flag_n_o) |-> $past(push))
    else $error("empty flag rose without write");
  a_empty_fall_cause: assert property ($fell(empty_flag_n_o) |-> $past(rreq))
    else $error("empty flag fell without read");
  a_full_rise_cause: assert property ($rose(full_flag_n_o) |-> $past(rreq))
    else $error("full flag rose without read");
  a_ae_rise_cause: assert property ($rose(almost_empty_flag_n_o) |-> $past(push))
    else $error("almost empty rose without write");
  a_af_rise_cause: assert property ($rose(almost_full_flag_n_o) |-> $past(rreq))
    else $error("almost full rose without read");
  a_mail_read_clear: assert property (rmb && !wreq |=> !mail_full_o)
    else $error("mailbox flag kept after read");
  a_data_hold: assert property (!rreq |=> $stable(read_data_o))
    else $error("read data changed without read");
  c_mail_read: cover property (rmb);
  c_full_free: cover property ($rose(full_flag_n_o));
  c_empty_set: cover property ($fell(empty_flag_n_o));
endmodule
bind fbm_top fbm_top_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .write_port_select_n_i(write_port_select_n_i),
  .write_port_direction_i(write_port_direction_i),
  .write_port_enable_i(write_port_enable_i),
  .write_port_mailbox_select_i(write_port_mailbox_select_i),
  .read_port_select_n_i(read_port_select_n_i),
  .read_port_direction_i(read_port_direction_i),
  .read_port_enable_i(read_port_enable_i),
  .read_port_mailbox_select_i(read_port_mailbox_select_i),
  .read_data_o(read_data_o), .empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o),
  .almost_empty_flag_n_o(almost_empty_flag_n_o),
  .almost_full_flag_n_o(almost_full_flag_n_o), .mail_full_o(mail_full_o));

// >>> fbm_top_bench.sv
// Self-checking bench of the FIFO read port block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, (g), (e)); end end
module fbm_top_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, perr, irq;
  logic        wsel_n, wdir, wen, wmb, rsel_n, rdir, ren, rmb;
  logic        ef_n, ff_n, ae_n, af_n, mf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [35:0] wdata, rdata, w, ex;
  int          n_fail = 0, compares = 0, ln;
  always #12.5 clk = ~clk;
  fbm_top DUT (.core_clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .write_port_select_n_i(wsel_n),
    .write_port_direction_i(wdir), .write_port_enable_i(wen),
    .write_port_mailbox_select_i(wmb), .write_data_i(wdata), .read_port_select_n_i(rsel_n),
    .read_port_direction_i(rdir), .read_port_enable_i(ren), .read_port_mailbox_select_i(rmb),
    .read_data_o(rdata), .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n),
    .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n), .mail_full_o(mf));
  fbm_port_b_host host (.core_clk_i(clk), .sel_n_o(rsel_n), .dir_o(rdir), .en_o(ren),
    .mb_o(rmb));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail++;
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic push(input logic [35:0] d, input logic m);
    @(posedge clk);
    wsel_n <= 1'b0;
    wdir <= 1'b1;
    wen <= 1'b1;
    wmb <= m;
    wdata <= d;
    @(posedge clk);
    wsel_n <= 1'b1;
    wdir <= 1'b0;
    wen <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic nap(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rdx(input logic m, input logic [35:0] e);
    host.rd(m, 0);
    nap(1);
    `CHK(rdata, e)
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    {wsel_n, wdir, wen, wmb, wdata} = {1'b1, 39'h0};
    ex = 36'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    nap(1);
    `CHK({ef_n, ff_n, ae_n, af_n, mf, rdata}, {5'b01010, 36'h0})
    apb(0, 12'h004, 0);
    `CHK(r, 32'h0000_000A)
    apb(0, 12'h008, 0);
    `CHK(r, 32'h0008_0008)
    apb(0, 12'h020, 0);
    `CHK({perr, r}, {1'b1, 32'h0})
    apb(1, 12'h008, 0);
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 2; e++) begin
        w = 36'h9_A5C3_5A3C ^ 36'(s * 8 + e);
        apb(1, 12'h000, 32'(2 + s * 4 + e * 16));
        push(w, 1'b0);
        nap(1);
        `CHK(ef_n, 1'b1)
        for (int k = 0; k < 4; k++) begin
          ln = e ? 3 - k : k;
          ex[e * 27 +: 9] = w[(ln ^ ((4 - s) & 3)) * 9 +: 9];
          host.rd(1'b0, k);
          nap(1);
          `CHK(rdata, ex)
          `CHK({ef_n, ae_n}, {2{k != 3}})
        end
      end
    end
    apb(1, 12'h000, 32'h0000_0011);
    w = 36'h1_2345_6789;
    push(w, 1'b0);
    push(36'hF_EDCB_A987, 1'b0);
    ex[35:18] = w[35:18];
    rdx(0, ex);
    apb(0, 12'h004, 0);
    `CHK(r[14:8], 7'd2)
    ex[35:18] = w[17:0];
    rdx(0, ex);
    apb(0, 12'h004, 0);
    `CHK(r[14:8], 7'd1)
    apb(1, 12'h000, 32'h0000_0005);
    w = 36'hF_EDCB_A987;
    ex[17:0] = {w[26:18], w[35:27]};
    rdx(0, ex);
    `CHK(ef_n, 1'b1)
    ex[17:0] = {w[8:0], w[17:9]};
    rdx(0, ex);
    `CHK(ef_n, 1'b0)
    apb(1, 12'h000, 32'h0000_0008);
    w = 36'h3_0C0F_F0A5;
    push(w, 1'b0);
    rdx(0, {w[17:0], w[35:18]});
    w = 36'h0_E062_0100;
    push(w, 1'b1);
    nap(1);
    `CHK(mf, 1'b1)
    apb(1, 12'h000, 32'h0000_0003);
    rdx(0, w);
    `CHK(mf, 1'b0)
    apb(1, 12'h000, 32'h0000_0023);
    ex = w;
    for (int b = 0; b < 4; b++) ex[b * 9 + 8] = ^w[b * 9 +: 8];
    rdx(1, ex);
    apb(1, 12'h000, 32'h0000_0063);
    for (int b = 0; b < 4; b++) ex[b * 9 + 8] = ~^w[b * 9 +: 8];
    rdx(1, ex);
    apb(1, 12'h000, 32'h0000_0003);
    rdx(1, w);
    apb(1, 12'h000, 0);
    apb(0, 12'h00C, 0);
    host.rd(1'b0, 0);
    nap(2);
    `CHK(irq, 1'b0)
    apb(1, 12'h010, 32'h0000_0008);
    nap(2);
    `CHK(irq, 1'b1)
    apb(0, 12'h00C, 0);
    `CHK(r[3], 1'b1)
    nap(2);
    `CHK(irq, 1'b0)
    apb(1, 12'h000, 32'h0000_0012);
    for (int i = 0; i < 65; i++) push(36'h9_8765_4300 + 36'(i), 1'b0);
    nap(1);
    `CHK({ff_n, af_n}, 2'b00)
    for (int k = 0; k < 4; k++) begin
      host.rd(1'b0, 0);
      nap(1);
      `CHK({ff_n, af_n}, {2{k == 3}})
    end
    apb(1, 12'h000, 0);
    for (int i = 1; i < 64; i++) rdx(0, 36'h9_8765_4300 + 36'(i));
    `CHK(ef_n, 1'b0)
    report_and_stop();
  end
  initial begin
    #(25 * 5000);
    n_fail++;
    report_and_stop();
  end
endmodule
